// ### hw/musr_top.sv
// Status, upgrade status and latch registers of the management map.
// Assumes reads and core events arrive synchronous to SYS_CLK.
`include "musr_defines.svh"

module musr_top
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic RD_STB,
    input wire logic [15:0] RD_ADDR,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    input wire logic WR_PENDING,
    input wire logic CMD_STB,
    input wire logic [3:0] CMD_CODE,
    input wire logic ENGINE_DONE,
    input wire logic ENGINE_FAIL,
    input wire logic [6:0] FAIL_CODE,
    input wire logic SVC_AFFECT,
    input wire musr_pkg::musr_slot_t SLOT_A,
    input wire musr_pkg::musr_slot_t SLOT_B,
    input wire logic UPLOAD_AVAIL,
    input wire logic UPLOAD_DONE,
    input wire logic BLK_SET,
    input wire logic BLK_CONSUMED,
    output logic BLK_READY,
    output logic CMD_GO
);
    import musr_pkg::*;

    musr_latch_if lif ();

    // ==============================================================
    // Command tracker state
    musr_state_t state;
    musr_state_t next_state;
    musr_prog_t prog;
    musr_prog_t next_prog;
    musr_cmd_t cur_cmd;
    musr_cmd_t next_cur_cmd;
    logic [6:0] reason;
    logic [6:0] next_reason;
    logic cmd_err;
    logic next_cmd_err;
    logic running;
    logic next_running;
    logic committed;
    logic next_committed;
    logic wr_ready;
    logic next_wr_ready;
    logic go;
    logic next_go;
    logic blk;
    logic next_blk;

    // Host-side read port state
    logic [15:0] rd_data;
    logic [15:0] next_rd_data;
    logic rd_valid;
    logic next_rd_valid;

    // Codes above the last command or zero never start the engine
    function automatic logic cmd_known(input logic [3:0] c);
        cmd_known = (c != 4'h0) && (c <= `MUSR_NUM_CMDS);
    endfunction : cmd_known

    // ==============================================================
    // Command acceptance, progress and outcome
    always_comb
    begin
        next_state = state;
        next_prog = prog;
        next_cur_cmd = cur_cmd;
        next_reason = reason;
        next_cmd_err = cmd_err;
        next_running = running;
        next_committed = committed;
        next_go = 1'b0;
        case (state)
            MUSR_ST_IDLE:
            begin
                if (CMD_STB && cmd_known(CMD_CODE))
                begin
                    next_state = MUSR_ST_BUSY;
                    next_prog = MUSR_PROG_BUSY;
                    next_cur_cmd = musr_cmd_t'(CMD_CODE);
                    next_reason = `MUSR_RST_REASON;
                    next_cmd_err = 1'b0;
                    next_go = 1'b1;
                end
                else if (CMD_STB && CMD_CODE != 4'h0)
                begin
                    next_cmd_err = 1'b1;
                end
            end
            MUSR_ST_BUSY:
            begin
                // A new command while busy is refused, engine unaffected
                if (CMD_STB && CMD_CODE != 4'h0)
                begin
                    next_cmd_err = 1'b1;
                end
                // Failure is checked first: a done pulse alongside a failure has no effect
                if (ENGINE_FAIL)
                begin
                    next_state = MUSR_ST_IDLE;
                    next_prog = MUSR_PROG_FAIL;
                    next_reason = FAIL_CODE;
                end
                else if (ENGINE_DONE)
                begin
                    next_state = MUSR_ST_IDLE;
                    next_prog = MUSR_PROG_OK;
                    case (cur_cmd)
                        MUSR_CMD_RUN_A: next_running = 1'b0;
                        MUSR_CMD_RUN_B: next_running = 1'b1;
                        MUSR_CMD_COMMIT_A: next_committed = 1'b0;
                        MUSR_CMD_COMMIT_B: next_committed = 1'b1;
                        default: next_running = running;
                    endcase
                end
            end
            default:
            begin
                next_state = MUSR_ST_IDLE;
                next_prog = MUSR_PROG_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            state <= MUSR_ST_IDLE;
            prog <= MUSR_PROG_IDLE;
            cur_cmd <= MUSR_CMD_NOP;
            reason <= `MUSR_RST_REASON;
            cmd_err <= 1'b0;
            running <= 1'b0;
            committed <= 1'b0;
            go <= 1'b0;
        end
        else
        begin
            state <= next_state;
            prog <= next_prog;
            cur_cmd <= next_cur_cmd;
            reason <= next_reason;
            cmd_err <= next_cmd_err;
            running <= next_running;
            committed <= next_committed;
            go <= next_go;
        end
    end

    // ==============================================================
    // Write-ready flag and block handshake; host set beats the clear
    always_comb
    begin
        next_wr_ready = !WR_PENDING;
        next_blk = blk;
        if (BLK_CONSUMED)
        begin
            next_blk = 1'b0;
        end
        if (BLK_SET)
        begin
            next_blk = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            wr_ready <= 1'b0;
            blk <= 1'b0;
        end
        else
        begin
            wr_ready <= next_wr_ready;
            blk <= next_blk;
        end
    end

    // ==============================================================
    // Latch copies; a latch read clears those whose flag is no longer set
    assign lif.cond = {wr_ready, cmd_err};
    assign lif.clr = RD_STB && RD_ADDR == `MUSR_OFF_EXT_LATCH;

    musr_latch u_latch
    (
        .clk (SYS_CLK),
        .rst (RST),
        .lif (lif)
    );

    // ==============================================================
    // Read mux; unmapped addresses read zero, reserved bits zero
    always_comb
    begin
        next_rd_data = `MUSR_RST_REG;
        next_rd_valid = RD_STB;
        if (RD_STB)
        begin
            case (RD_ADDR)
                `MUSR_OFF_EXT_STATUS:
                begin
                    next_rd_data[`MUSR_BIT_WR_READY] = wr_ready;
                    next_rd_data[`MUSR_BIT_CMD_ERR] = cmd_err;
                    next_rd_data[`MUSR_BIT_UPLOAD_AVAIL] = UPLOAD_AVAIL;
                    next_rd_data[`MUSR_BIT_UPLOAD_DONE] = UPLOAD_DONE;
                end
                `MUSR_OFF_UPG_STATUS:
                begin
                    next_rd_data[15:14] = prog;
                    next_rd_data[`MUSR_BIT_SVC_AFFECT] = SVC_AFFECT;
                    next_rd_data[`MUSR_BIT_RUNNING] = running;
                    next_rd_data[11:10] = SLOT_A;
                    next_rd_data[9:8] = SLOT_B;
                    next_rd_data[`MUSR_BIT_COMMITTED] = committed;
                    next_rd_data[6:0] = reason;
                end
                `MUSR_OFF_EXT_LATCH:
                begin
                    next_rd_data[15:14] = lif.held;
                end
                default:
                begin
                    next_rd_data = `MUSR_RST_REG;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            rd_data <= `MUSR_RST_REG;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    assign RD_DATA = rd_data;
    assign RD_VALID = rd_valid;
    assign BLK_READY = blk;
    assign CMD_GO = go;

    // ==============================================================
    // Checks
    AST_WR_READY: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (RD_STB && RD_ADDR == `MUSR_OFF_EXT_STATUS)
        |=> RD_DATA[15] == $past(wr_ready))
        else $error("write-ready bit mismatch");

    AST_CMD_ERR: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (CMD_STB && CMD_CODE > `MUSR_NUM_CMDS) |=> cmd_err)
        else $error("unknown command left no error");

    AST_PROG_BUSY: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (state == MUSR_ST_IDLE && CMD_STB && cmd_known(CMD_CODE))
        |=> prog == MUSR_PROG_BUSY && go ##1 !go)
        else $error("accepted command not shown in progress");

    AST_PROG_FAIL: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (state == MUSR_ST_BUSY && ENGINE_FAIL)
        |=> prog == MUSR_PROG_FAIL && reason == $past(FAIL_CODE))
        else $error("failure not reported with its reason");

    AST_SVC_SLOTS: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (RD_STB && RD_ADDR == `MUSR_OFF_UPG_STATUS)
        |=> RD_DATA[11:8] == {$past(SLOT_A), $past(SLOT_B)}
            && RD_DATA[13] == $past(SVC_AFFECT))
        else $error("slot or service bits mismatch");

    AST_LATCH_READ: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (lif.clr && !wr_ready && !cmd_err) |=> lif.held == 2'h0)
        else $error("latch not cleared by read");

    AST_BLK: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (BLK_CONSUMED && !BLK_SET) |=> !BLK_READY)
        else $error("block-ready not cleared");

endmodule : musr_top

// ### hw/musr_defines.svh
// Register offsets, field positions and reset values of the upgrade
// status bank. Assumes a 16-bit management address space.
`ifndef MUSR_DEFINES_SVH
`define MUSR_DEFINES_SVH

// ==================================================================
// Offsets
`define MUSR_OFF_EXT_STATUS 16'hB050
`define MUSR_OFF_UPG_STATUS 16'hB051
`define MUSR_OFF_EXT_LATCH 16'hB054

// ==================================================================
// Field positions
`define MUSR_BIT_WR_READY 15
`define MUSR_BIT_CMD_ERR 14
`define MUSR_BIT_UPLOAD_AVAIL 8
`define MUSR_BIT_UPLOAD_DONE 7
`define MUSR_BIT_SVC_AFFECT 13
`define MUSR_BIT_RUNNING 12
`define MUSR_BIT_COMMITTED 7

// ==================================================================
// Reset values and command count
`define MUSR_RST_REG 16'h0000
`define MUSR_RST_REASON 7'h00
`define MUSR_NUM_CMDS 4'h9

`endif

// ### hw/musr_pkg.sv
// Types shared by the upgrade status bank.
// Assumes the defines header is compiled alongside.
package musr_pkg;

    // ==============================================================
    // Command progress as reported to the host
    typedef enum logic [1:0]
    {
        MUSR_PROG_IDLE = 2'b00,
        MUSR_PROG_OK = 2'b01,
        MUSR_PROG_BUSY = 2'b10,
        MUSR_PROG_FAIL = 2'b11
    } musr_prog_t;

    // Image slot state
    typedef enum logic [1:0]
    {
        MUSR_SLOT_NONE = 2'b00,
        MUSR_SLOT_VALID = 2'b01,
        MUSR_SLOT_BAD = 2'b10,
        MUSR_SLOT_RSVD = 2'b11
    } musr_slot_t;

    // Host upgrade commands
    typedef enum logic [3:0]
    {
        MUSR_CMD_NOP = 4'h0,
        MUSR_CMD_DL_START = 4'h1,
        MUSR_CMD_DL_DONE = 4'h2,
        MUSR_CMD_RUN_A = 4'h3,
        MUSR_CMD_RUN_B = 4'h4,
        MUSR_CMD_ABORT = 4'h5,
        MUSR_CMD_COPY_AB = 4'h6,
        MUSR_CMD_COPY_BA = 4'h7,
        MUSR_CMD_COMMIT_A = 4'h8,
        MUSR_CMD_COMMIT_B = 4'h9
    } musr_cmd_t;

    // Command tracker states, codes left to the tool
    typedef enum
    {
        MUSR_ST_IDLE,
        MUSR_ST_BUSY
    } musr_state_t;

endpackage : musr_pkg

// ### hw/musr_latch_if.sv
// Carrier between the status core and its latch copies.
// Assumes both ends share SYS_CLK.
interface musr_latch_if;
    logic [1:0] cond;
    logic clr;
    logic [1:0] held;

    modport core (output cond, output clr, input held);
    modport latch (input cond, input clr, output held);
endinterface : musr_latch_if

// ### hw/musr_latch.sv
// Sticky latch copies of the write-ready and command-error flags.
// Assumes clr is a one-cycle pulse from a host read.
module musr_latch
(
    input wire logic clk,
    input wire logic rst,
    musr_latch_if.latch lif
);
    import musr_pkg::*;

    logic [1:0] held;
    logic [1:0] next_held;

    // ==============================================================
    // Set wins over a read clear so no event is lost
    always_comb
    begin
        next_held = held;
        if (lif.clr)
        begin
            next_held = 2'h0;
        end
        next_held = next_held | lif.cond;
    end

    // Register only
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            held <= 2'h0;
        end
        else
        begin
            held <= next_held;
        end
    end

    assign lif.held = held;

    // A set bit stays set until a read clear
    AST_LATCH_HOLD: assert property (
        @(posedge clk) disable iff (rst)
        (held[1] && !lif.clr) |=> held[1])
        else $error("latch bit dropped without a read");

    // An asserted condition is latched next cycle even under a clear
    AST_LATCH_SET: assert property (
        @(posedge clk) disable iff (rst)
        lif.cond[0] |=> held[0])
        else $error("command error not latched");

endmodule : musr_latch

// ### bench/musr_host.sv
// Host model on the management side: reads, commands, block flag.
// Assumes the device takes requests on the rising edge of clk.
module musr_host
(
    input wire logic clk,
    output logic rd_stb,
    output logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    output logic cmd_stb,
    output logic [3:0] cmd_code,
    output logic blk_set
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Idle levels at time zero
    initial
    begin
        rd_stb = 1'b0;
        rd_addr = 16'hFFFF;
        cmd_stb = 1'b0;
        cmd_code = 4'hF;
        blk_set = 1'b0;
    end

    // ==========================================================
    // One read; released address is inverted so stale use shows
    task automatic read_reg(input logic [15:0] a,
        output logic [15:0] d, output logic v);
        @(posedge clk);
        rd_stb <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        rd_addr <= ~a;
        #1;
        d = rd_data;
        v = rd_valid;
    endtask : read_reg

    // One command write, code field only four bits wide
    task automatic send_cmd(input logic [3:0] c);
        @(posedge clk);
        cmd_stb <= 1'b1;
        cmd_code <= c;
        @(posedge clk);
        cmd_stb <= 1'b0;
        cmd_code <= ~c;
        #1;
    endtask : send_cmd

    // Block written; flag raised for one cycle
    task automatic set_blk();
        @(posedge clk);
        blk_set <= 1'b1;
        @(posedge clk);
        blk_set <= 1'b0;
        #1;
    endtask : set_blk
endmodule : musr_host

// ### bench/musr_top_tb.sv
// Self-checking bench for the upgrade status bank.
// Assumes the host model drives reads, commands and block flags.
`include "musr_defines.svh"

module musr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import musr_pkg::*;

    // ==========================================================
    // Signals
    logic sys_clk, rst, rd_stb, rd_valid, wr_pending, cmd_stb, cmd_go;
    logic engine_done, engine_fail, svc, up_avail, up_done;
    logic blk_set, blk_consumed, blk_ready, run, com;
    logic [15:0] rd_addr, rd_data;
    logic [3:0] cmd_code;
    logic [6:0] fail_code;
    musr_slot_t slot_a, slot_b;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    musr_top i_dut
    (
        .SYS_CLK(sys_clk), .RST(rst), .RD_STB(rd_stb), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .WR_PENDING(wr_pending),
        .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .ENGINE_DONE(engine_done),
        .ENGINE_FAIL(engine_fail), .FAIL_CODE(fail_code),
        .SVC_AFFECT(svc), .SLOT_A(slot_a), .SLOT_B(slot_b),
        .UPLOAD_AVAIL(up_avail), .UPLOAD_DONE(up_done),
        .BLK_SET(blk_set), .BLK_CONSUMED(blk_consumed),
        .BLK_READY(blk_ready), .CMD_GO(cmd_go)
    );

    musr_host i_host
    (
        .clk(sys_clk), .rd_stb(rd_stb), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .cmd_stb(cmd_stb),
        .cmd_code(cmd_code), .blk_set(blk_set)
    );

    // ==========================================================
    // Clock, 5 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Hang guard; tests need under two hundred cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    // Read one word and compare both data and valid pulse
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        i_host.read_reg(a, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask : rd

    // Command write, then look at the accept pulse
    task automatic cmd(input logic [3:0] c, input logic go);
        i_host.send_cmd(c);
        check({15'h0000, cmd_go}, {15'h0000, go});
    endtask : cmd

    // Engine outcome pulse
    task automatic engine(input logic ok, input logic bad,
        input logic [6:0] why);
        @(posedge sys_clk);
        engine_done <= ok;
        engine_fail <= bad;
        fail_code <= why;
        @(posedge sys_clk);
        engine_done <= 1'b0;
        engine_fail <= 1'b0;
    endtask : engine

    function automatic logic [15:0] upg(input logic [1:0] p,
        input logic [6:0] why);
        return {p, svc, run, slot_a, slot_b, com, why};
    endfunction : upg

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(`MUSR_OFF_EXT_STATUS, 16'h0000);
        rd(`MUSR_OFF_UPG_STATUS, 16'h0000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h0000);
        rd(16'hB052, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ready();
        @(posedge sys_clk);
        wr_pending <= 1'b0;
        up_avail <= 1'b1;
        up_done <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(`MUSR_OFF_EXT_STATUS, 16'h8180);
        rd(`MUSR_OFF_EXT_LATCH, 16'h8000);
        @(posedge sys_clk);
        wr_pending <= 1'b1;
        up_avail <= 1'b0;
        up_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(`MUSR_OFF_EXT_STATUS, 16'h0000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h8000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h0000);
        $display("test ready done");
    endtask : t_ready

    // Command codes 1 to 9, every slot code, both service levels
    task automatic t_cmds();
        for (int i = 1; i <= 9; i++)
        begin
            @(posedge sys_clk);
            slot_a <= musr_slot_t'(i[1:0]);
            slot_b <= musr_slot_t'(~i[1:0]);
            svc <= i[0];
            cmd(i[3:0], 1'b1);
            rd(`MUSR_OFF_UPG_STATUS, upg(2'b10, 7'h00));
            engine(1'b1, 1'b0, 7'h00);
            run = (i == 4) ? 1'b1 : ((i == 3) ? 1'b0 : run);
            com = (i == 9) ? 1'b1 : ((i == 8) ? 1'b0 : com);
            rd(`MUSR_OFF_UPG_STATUS, upg(2'b01, 7'h00));
        end
        $display("test commands done");
    endtask : t_cmds

    // Refused codes, one busy refusal, failure reasons 1 to 4
    task automatic t_errs();
        cmd(4'h0, 1'b0);
        rd(`MUSR_OFF_EXT_STATUS, 16'h0000);
        cmd(4'hA, 1'b0);
        rd(`MUSR_OFF_EXT_STATUS, 16'h4000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h4000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h4000);
        cmd(4'h4, 1'b1);
        rd(`MUSR_OFF_EXT_STATUS, 16'h0000);
        cmd(4'h3, 1'b0);
        rd(`MUSR_OFF_EXT_STATUS, 16'h4000);
        for (int w = 1; w <= 4; w++)
        begin
            engine(1'b1, 1'b1, w[6:0]);
            rd(`MUSR_OFF_UPG_STATUS, upg(2'b11, w[6:0]));
            cmd(4'h4, 1'b1);
        end
        engine(1'b1, 1'b0, 7'h00);
        rd(`MUSR_OFF_UPG_STATUS, upg(2'b01, 7'h00));
        rd(`MUSR_OFF_EXT_LATCH, 16'h4000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h0000);
        $display("test errors done");
    endtask : t_errs

    // Block flag: set, consume, then both in one cycle
    task automatic t_blk();
        i_host.set_blk();
        check({15'h0000, blk_ready}, 16'h0001);
        @(posedge sys_clk);
        blk_consumed <= 1'b1;
        @(posedge sys_clk);
        blk_consumed <= 1'b0;
        #1;
        check({15'h0000, blk_ready}, 16'h0000);
        fork
            i_host.set_blk();
            begin
                @(posedge sys_clk);
                blk_consumed <= 1'b1;
                @(posedge sys_clk);
                blk_consumed <= 1'b0;
            end
        join
        check({15'h0000, blk_ready}, 16'h0001);
        $display("test block done");
    endtask : t_blk

    // Reset in mid-run: bank back to zero, idle engine pulse ignored
    task automatic t_rerst();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        engine(1'b1, 1'b0, 7'h00);
        run = 1'b0;
        com = 1'b0;
        rd(`MUSR_OFF_UPG_STATUS, upg(2'b00, 7'h00));
        rd(`MUSR_OFF_EXT_STATUS, 16'h0000);
        rd(`MUSR_OFF_EXT_LATCH, 16'h0000);
        check({15'h0000, blk_ready}, 16'h0000);
        check({15'h0000, cmd_go}, 16'h0000);
        $display("test mid-run reset done");
    endtask : t_rerst

    // ==========================================================
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // Main sequence; pending write held during reset keeps status at 0
    initial
    begin
        rst = 1'b1;
        wr_pending = 1'b1;
        engine_done = 1'b0;
        engine_fail = 1'b0;
        fail_code = 7'h00;
        svc = 1'b0;
        up_avail = 1'b0;
        up_done = 1'b0;
        blk_consumed = 1'b0;
        slot_a = MUSR_SLOT_NONE;
        slot_b = MUSR_SLOT_NONE;
        run = 1'b0;
        com = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_ready();
        t_cmds();
        t_errs();
        t_blk();
        t_rerst();
        tally_and_finish();
    end
endmodule : musr_top_tb
